// >>> common/ufic_defs.vh
// Constants of the transceiver function and interface control block.
`ifndef UFIC_DEFS_VH
`define UFIC_DEFS_VH

// ==========================================================================
// Register indices; the APB byte address is four times the index.
`define UFIC_IDX_FUNC 6'h04
`define UFIC_IDX_FUNC_SET 6'h05
`define UFIC_IDX_FUNC_CLR 6'h06
`define UFIC_IDX_IFC 6'h07
`define UFIC_IDX_IFC_SET 6'h08
`define UFIC_IDX_IFC_CLR 6'h09
`define UFIC_IDX_STATUS 6'h10

// ==========================================================================
// Function control layout and reset value.
`define UFIC_FN_RESET 8'h41
`define UFIC_FN_MASK 8'h7F
`define UFIC_FN_LP_N 6
`define UFIC_FN_XRST 5
`define UFIC_FN_STYLE_HI 4
`define UFIC_FN_STYLE_LO 3
`define UFIC_FN_TERM 2
`define UFIC_FN_SPD_HI 1
`define UFIC_FN_SPD_LO 0

// ==========================================================================
// Interface control layout and reset value.
`define UFIC_IF_RESET 8'h00
`define UFIC_IF_MASK 8'hFF
`define UFIC_IF_PROT_DIS 7
`define UFIC_IF_UNQUAL 6
`define UFIC_IF_INVERT 5
`define UFIC_IF_AUTORES 4
`define UFIC_IF_CLK_PWR_N 3
`define UFIC_IF_UART 2
`define UFIC_IF_SER3 1
`define UFIC_IF_SER6 0

// ==========================================================================
// Line drive styles and speed choices.
`define UFIC_STYLE_NORMAL 2'h0
`define UFIC_STYLE_NONDRIVE 2'h1
`define UFIC_STYLE_RAW 2'h2
`define UFIC_STYLE_RSVD 2'h3
`define UFIC_SPD_HS 2'h0
`define UFIC_SPD_FS 2'h1
`define UFIC_SPD_LS 2'h2
`define UFIC_SPD_FS_LS 2'h3

// ==========================================================================
// Status register bit positions.
`define UFIC_ST_LP 0
`define UFIC_ST_BUSY 1
`define UFIC_ST_DIR 2
`define UFIC_ST_VBUS 3
`define UFIC_ST_UART 4
`define UFIC_ST_SERIAL 5
`define UFIC_ST_RESUME 6

// ==========================================================================
// Pin synchroniser layout and core reset sequencing.
`define UFIC_SYNC_W 7
`define UFIC_PIN_LCLK 0
`define UFIC_PIN_STP 1
`define UFIC_PIN_D0 2
`define UFIC_PIN_DP 3
`define UFIC_PIN_VFLAG 4
`define UFIC_PIN_VCMP 5
`define UFIC_PIN_RESUME 6
`define UFIC_CORE_RST_EDGES 8'h08
`define UFIC_SEQ_IDLE 2'h0
`define UFIC_SEQ_HOLD 2'h1
`define UFIC_SEQ_DROP 2'h2
`define UFIC_SEQ_REPORT 2'h3

`endif

// >>> rtl/ufic_sync.v
// Two flip-flop synchroniser for pins from outside the clock domain.
`default_nettype none
module ufic_sync #(
  parameter W = 7
) (
  // Clock and reset.
  input wire ref_clk,
  input wire rstn,
  // Asynchronous pins and their synchronised copy.
  input wire [W-1:0] pin_in,
  output reg [W-1:0] pin_sync
);
  reg [W-1:0] meta_q;

  // ========================================================================
  // Synchroniser
  // The first stage feeds only the second stage, never any logic.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      meta_q <= {W{1'b0}};
      pin_sync <= {W{1'b0}};
    end else begin
      meta_q <= pin_in;
      pin_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ufic_rst_seq.v
// Transceiver core reset sequencer with its direction handshake.
`include "ufic_defs.vh"
`default_nettype none
module ufic_rst_seq (
  // Clock and reset.
  input wire ref_clk,
  input wire rstn,
  // Start request and link clock edge enable.
  input wire start,
  input wire link_edge,
  // Sequence outputs.
  output reg seq_dir,
  output reg core_reset,
  output reg bit_clear,
  output reg rxcmd_send,
  output wire busy
);
  reg [1:0] state_q;
  reg [7:0] edges_q;

  assign busy = (state_q != `UFIC_SEQ_IDLE);

  // ========================================================================
  // Sequencer
  // The core is held for a count of link clock edges so that its own
  // logic, which runs on that clock, sees a full reset.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      state_q <= `UFIC_SEQ_IDLE;
      edges_q <= 8'h00;
      seq_dir <= 1'b0;
      core_reset <= 1'b0;
      bit_clear <= 1'b0;
      rxcmd_send <= 1'b0;
    end else begin
      bit_clear <= 1'b0;
      rxcmd_send <= 1'b0;
      case (state_q)
        `UFIC_SEQ_IDLE: begin
          if (start) begin
            state_q <= `UFIC_SEQ_HOLD;
            edges_q <= 8'h00;
            seq_dir <= 1'b1;
            core_reset <= 1'b1;
          end
        end
        `UFIC_SEQ_HOLD: begin
          if (link_edge) begin
            edges_q <= edges_q + 8'h01;
          end
          if (link_edge && edges_q == `UFIC_CORE_RST_EDGES - 8'h01) begin
            state_q <= `UFIC_SEQ_DROP;
            core_reset <= 1'b0;
            seq_dir <= 1'b0;
            bit_clear <= 1'b1;
          end
        end
        `UFIC_SEQ_DROP: begin
          state_q <= `UFIC_SEQ_REPORT;
          seq_dir <= 1'b1;
          rxcmd_send <= 1'b1;
        end
        `UFIC_SEQ_REPORT: begin
          state_q <= `UFIC_SEQ_IDLE;
          seq_dir <= 1'b0;
        end
        default: begin
          state_q <= `UFIC_SEQ_IDLE;
          seq_dir <= 1'b0;
          core_reset <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ufic_top.v
// Function and interface control registers of a USB transceiver.
`include "ufic_defs.vh"
`default_nettype none

// ==========================================================================
module ufic_top (
  // Clock and reset.
  input wire ref_clk,
  input wire rstn,
  // APB register port.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // Link side pins; the inputs are asynchronous to ref_clk, the outputs are registered on it.
  input wire link_clk,
  input wire link_stp,
  input wire link_d0,
  output reg dir,
  output reg ulpi_d1_out,
  output reg ulpi_d1_oe,
  output reg interface_protect_en,
  // Analog front end pins; the inputs are asynchronous to ref_clk, the outputs are registered on it.
  input wire dp_rx,
  input wire offchip_vbus_flag,
  input wire vbus_valid_cmp,
  input wire bus_resume_seen,
  input wire dp_pulldown,
  input wire dm_pulldown,
  output reg dm_tx_out,
  output reg dm_tx_oe,
  // Transceiver core controls.
  output reg phy_low_power_n,
  output reg core_reset,
  output reg [1:0] line_drive_style,
  output reg hs_xcvr_en,
  output reg fs_xcvr_en,
  output reg ls_xcvr_en,
  output reg fs_preamble_en,
  output reg hs_term_en,
  output reg fs_pullup_en,
  output reg serial_clock_on,
  output reg resume_drive,
  output reg uart_bridge_enable,
  output reg three_wire_serial_enable,
  output reg six_wire_serial_enable,
  output reg rxcmd_send,
  output reg rxcmd_vbus
);
  // ========================================================================
  // Declarations
  wire [`UFIC_SYNC_W-1:0] pins_s;
  wire seq_dir;
  wire seq_core_reset;
  wire seq_clear;
  wire seq_rxcmd;
  wire seq_busy;
  reg [7:0] func_q;
  reg [7:0] func_d;
  reg [7:0] ifc_q;
  reg [7:0] ifc_d;
  reg lclk_prev_q;
  reg stp_prev_q;
  reg lp_active_q;
  reg resume_q;
  reg [31:0] rd_d;
  reg err_d;
  wire [5:0] idx;
  wire setup;
  wire wr_en;
  wire link_edge;
  wire stp_rise;
  wire lp_exit;
  wire mode_exit;
  wire serial_any;
  wire xrst_start;
  wire vbus_comp;
  wire vbus_report;
  wire [7:0] wbyte;
  wire [7:0] status;

  // ========================================================================
  // Pin synchronisers
  // Every pin except dp_pulldown and dm_pulldown passes two flops before any logic here reads it.
  ufic_sync #(
    .W(`UFIC_SYNC_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin_in({bus_resume_seen, vbus_valid_cmp, offchip_vbus_flag, dp_rx,
             link_d0, link_stp, link_clk}),
    .pin_sync(pins_s)
  );

  // Edge detectors work on the synchronised copies only.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      lclk_prev_q <= 1'b0;
      stp_prev_q <= 1'b0;
    end else begin
      lclk_prev_q <= pins_s[`UFIC_PIN_LCLK];
      stp_prev_q <= pins_s[`UFIC_PIN_STP];
    end
  end

  // The link clock is far slower than ref_clk, so each rise is one pulse.
  assign link_edge = pins_s[`UFIC_PIN_LCLK] & ~lclk_prev_q;
  assign stp_rise = pins_s[`UFIC_PIN_STP] & ~stp_prev_q;

  // ========================================================================
  // Core reset sequencer
  ufic_rst_seq u_seq (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(xrst_start),
    .link_edge(link_edge),
    .seq_dir(seq_dir),
    .core_reset(seq_core_reset),
    .bit_clear(seq_clear),
    .rxcmd_send(seq_rxcmd),
    .busy(seq_busy)
  );

  // ========================================================================
  // APB decode
  // Reads are latched in the setup cycle, so the slave never waits.
  assign idx = paddr[7:2];
  assign setup = psel & ~penable;
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & pstrb[0] & ~pslverr;
  assign wbyte = pwdata[7:0];

  // Exit events: the stop line wakes the part or ends a serial mode.
  assign lp_exit = lp_active_q & stp_rise;
  assign serial_any = ifc_q[`UFIC_IF_UART] | ifc_q[`UFIC_IF_SER3] |
                      ifc_q[`UFIC_IF_SER6];
  assign mode_exit = ~lp_active_q & serial_any & stp_rise;

  // ========================================================================
  // Function control next value
  always @* begin
    func_d = func_q;
    if (seq_clear) begin
      func_d[`UFIC_FN_XRST] = 1'b0;
    end
    if (wr_en) begin
      case (idx)
        `UFIC_IDX_FUNC: begin
          func_d = wbyte & `UFIC_FN_MASK;
        end
        `UFIC_IDX_FUNC_SET: begin
          func_d = (func_d | wbyte) & `UFIC_FN_MASK;
        end
        `UFIC_IDX_FUNC_CLR: begin
          func_d = func_d & ~wbyte;
        end
        default: begin
          func_d = func_d;
        end
      endcase
    end
    if (lp_exit) begin
      func_d[`UFIC_FN_LP_N] = 1'b1;
    end
    // The reset bit cannot be dropped by software while the core is held.
    if (seq_core_reset && !seq_clear) begin
      func_d[`UFIC_FN_XRST] = 1'b1;
    end
  end

  // start when idle
  // A request made while a sequence ends is kept and served next.
  assign xrst_start = func_d[`UFIC_FN_XRST] & ~seq_busy;

  // ========================================================================
  // Interface control next value
  // A software write in the exit cycle wins, so a new mode is not lost.
  always @* begin
    ifc_d = ifc_q;
    if (mode_exit) begin
      ifc_d[`UFIC_IF_UART] = 1'b0;
      ifc_d[`UFIC_IF_SER3] = 1'b0;
      ifc_d[`UFIC_IF_SER6] = 1'b0;
    end
    if (wr_en) begin
      case (idx)
        `UFIC_IDX_IFC: begin
          ifc_d = wbyte & `UFIC_IF_MASK;
        end
        `UFIC_IDX_IFC_SET: begin
          ifc_d = ifc_d | wbyte;
        end
        `UFIC_IDX_IFC_CLR: begin
          ifc_d = ifc_d & ~wbyte;
        end
        default: begin
          ifc_d = ifc_d;
        end
      endcase
    end
  end

  // ========================================================================
  // Register and low power state
  // rstn only, never core reset
  always @(posedge ref_clk) begin
    if (!rstn) begin
      func_q <= `UFIC_FN_RESET;
      ifc_q <= `UFIC_IF_RESET;
      lp_active_q <= 1'b0;
      resume_q <= 1'b0;
    end else begin
      func_q <= func_d;
      ifc_q <= ifc_d;
      if (lp_exit) begin
        lp_active_q <= 1'b0;
      end else if (!func_q[`UFIC_FN_LP_N]) begin
        lp_active_q <= 1'b1;
      end
      if (lp_exit || !lp_active_q) begin
        resume_q <= 1'b0;
      end else if (ifc_q[`UFIC_IF_AUTORES] && pins_s[`UFIC_PIN_RESUME]) begin
        resume_q <= 1'b1;
      end
    end
  end

  // ========================================================================
  // VBUS indicator path
  // optional inversion
  assign vbus_comp = pins_s[`UFIC_PIN_VFLAG] ^ ifc_q[`UFIC_IF_INVERT];
  assign vbus_report = ifc_q[`UFIC_IF_UNQUAL] ? vbus_comp :
                       (vbus_comp & pins_s[`UFIC_PIN_VCMP]);

  // ========================================================================
  // Status word
  assign status = {1'b0, resume_q,
                   ~ifc_q[`UFIC_IF_UART] & serial_any,
                   ifc_q[`UFIC_IF_UART], vbus_report, dir, seq_busy,
                   lp_active_q};

  // ========================================================================
  // Read data and error, captured in the setup cycle
  always @* begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    case (idx)
      `UFIC_IDX_FUNC, `UFIC_IDX_FUNC_SET, `UFIC_IDX_FUNC_CLR: begin
        rd_d = {24'h00_0000, func_q & ~(8'h01 << `UFIC_FN_XRST)};
      end
      `UFIC_IDX_IFC, `UFIC_IDX_IFC_SET, `UFIC_IDX_IFC_CLR: begin
        rd_d = {24'h00_0000, ifc_q};
      end
      `UFIC_IDX_STATUS: begin
        rd_d = {24'h00_0000, status};
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr <= err_d;
    end
  end

  // ========================================================================
  // Transceiver controls, all registered
  // Termination choice only makes sense together with speed, drive style
  // and the pulldowns, which mark host operation when both are on.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      phy_low_power_n <= 1'b1;
      core_reset <= 1'b0;
      dir <= 1'b0;
      rxcmd_send <= 1'b0;
      rxcmd_vbus <= 1'b0;
      line_drive_style <= `UFIC_STYLE_NORMAL;
      hs_xcvr_en <= 1'b0;
      fs_xcvr_en <= 1'b0;
      ls_xcvr_en <= 1'b0;
      fs_preamble_en <= 1'b0;
      hs_term_en <= 1'b0;
      fs_pullup_en <= 1'b0;
      serial_clock_on <= 1'b1;
      resume_drive <= 1'b0;
      interface_protect_en <= 1'b1;
      uart_bridge_enable <= 1'b0;
      three_wire_serial_enable <= 1'b0;
      six_wire_serial_enable <= 1'b0;
    end else begin
      phy_low_power_n <= ~lp_active_q;
      core_reset <= seq_core_reset;
      // The part owns the bus throughout low power and while the core is held in reset.
      dir <= seq_dir | lp_active_q;
      rxcmd_send <= seq_rxcmd | lp_exit;
      rxcmd_vbus <= vbus_report;
      if (func_q[`UFIC_FN_STYLE_HI:`UFIC_FN_STYLE_LO] == `UFIC_STYLE_RSVD) begin
        line_drive_style <= `UFIC_STYLE_NORMAL;
      end else begin
        line_drive_style <= func_q[`UFIC_FN_STYLE_HI:`UFIC_FN_STYLE_LO];
      end
      hs_xcvr_en <= func_q[`UFIC_FN_SPD_HI:`UFIC_FN_SPD_LO] == `UFIC_SPD_HS;
      fs_xcvr_en <= func_q[`UFIC_FN_SPD_HI:`UFIC_FN_SPD_LO] == `UFIC_SPD_FS
                    || func_q[`UFIC_FN_SPD_HI:`UFIC_FN_SPD_LO] ==
                    `UFIC_SPD_FS_LS;
      ls_xcvr_en <= func_q[`UFIC_FN_SPD_HI:`UFIC_FN_SPD_LO] == `UFIC_SPD_LS;
      fs_preamble_en <= func_q[`UFIC_FN_SPD_HI:`UFIC_FN_SPD_LO] ==
                        `UFIC_SPD_FS_LS;
      if (func_q[`UFIC_FN_STYLE_HI:`UFIC_FN_STYLE_LO] ==
          `UFIC_STYLE_NONDRIVE &&
          func_q[`UFIC_FN_SPD_HI:`UFIC_FN_SPD_LO] == `UFIC_SPD_HS) begin
        hs_term_en <= 1'b0;
        fs_pullup_en <= 1'b0;
      end else if (func_q[`UFIC_FN_SPD_HI:`UFIC_FN_SPD_LO] == `UFIC_SPD_HS)
      begin
        hs_term_en <= ~func_q[`UFIC_FN_TERM];
        fs_pullup_en <= func_q[`UFIC_FN_TERM] & ~(dp_pulldown & dm_pulldown);
      end else begin
        hs_term_en <= 1'b0;
        fs_pullup_en <= func_q[`UFIC_FN_TERM] & ~(dp_pulldown & dm_pulldown);
      end
      serial_clock_on <= ~lp_active_q &
                         (~serial_any | ifc_q[`UFIC_IF_CLK_PWR_N]);
      resume_drive <= resume_q;
      interface_protect_en <= ~ifc_q[`UFIC_IF_PROT_DIS];
      uart_bridge_enable <= ifc_q[`UFIC_IF_UART];
      three_wire_serial_enable <= ifc_q[`UFIC_IF_SER3];
      six_wire_serial_enable <= ifc_q[`UFIC_IF_SER6];
    end
  end

  // ========================================================================
  // UART line mapping
  // transmit on DM, receive from DP
  always @(posedge ref_clk) begin
    if (!rstn) begin
      dm_tx_out <= 1'b1;
      dm_tx_oe <= 1'b0;
      ulpi_d1_out <= 1'b1;
      ulpi_d1_oe <= 1'b0;
    end else begin
      dm_tx_out <= pins_s[`UFIC_PIN_D0];
      dm_tx_oe <= ifc_q[`UFIC_IF_UART];
      ulpi_d1_out <= pins_s[`UFIC_PIN_DP];
      ulpi_d1_oe <= ifc_q[`UFIC_IF_UART];
    end
  end
endmodule
`default_nettype wire

// >>> tb/ufic_checker.sv
// Port checker of the function and interface control block.
`default_nettype none
module ufic_checker (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // APB side.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Pins and core controls.
  input wire logic dir,
  input wire logic ulpi_d1_oe,
  input wire logic dm_tx_oe,
  input wire logic interface_protect_en,
  input wire logic phy_low_power_n,
  input wire logic core_reset,
  input wire logic [1:0] line_drive_style,
  input wire logic hs_xcvr_en,
  input wire logic fs_xcvr_en,
  input wire logic ls_xcvr_en,
  input wire logic fs_preamble_en,
  input wire logic serial_clock_on,
  input wire logic uart_bridge_enable,
  input wire logic rxcmd_send
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // ========================================================================
  // Sequences of the core reset hand-off.
  sequence s_drop;
    !dir;
  endsequence
  sequence s_report;
    dir && rxcmd_send ##1 !dir;
  endsequence

  // ========================================================================
  // Properties.
  property p_style;
    line_drive_style != 2'h3;
  endproperty
  property p_speed;
    (fs_preamble_en |-> fs_xcvr_en && !hs_xcvr_en && !ls_xcvr_en) and
    (hs_xcvr_en |-> !fs_xcvr_en && !ls_xcvr_en);
  endproperty
  // A write to the interface register is seen two edges later.
  property p_prot;
    (psel && penable && pwrite && pstrb[0] && paddr == 8'h1C) |->
      ##2 interface_protect_en == !$past(pwdata[7], 2);
  endproperty
  property p_lp;
    (!phy_low_power_n && !$past(phy_low_power_n)) |->
      dir && !serial_clock_on;
  endproperty
  property p_wake;
    $rose(phy_low_power_n) |-> $past(rxcmd_send);
  endproperty
  property p_rst_hold;
    $rose(core_reset) |-> (core_reset && dir) [*8];
  endproperty
  property p_rst_end;
    $fell(core_reset) |-> s_drop ##1 s_report;
  endproperty
  property p_rd0;
    (psel && !penable && paddr[7:2] >= 6'h04 && paddr[7:2] <= 6'h06) |=>
      prdata[7] == 1'b0 && prdata[5] == 1'b0 && prdata[31:8] == 24'h0;
  endproperty
  property p_slverr;
    (psel && !penable && (paddr[7:2] < 6'h04 || paddr[7:2] == 6'h3F))
      |=> pslverr && prdata == 32'h0;
  endproperty
  property p_uart;
    (uart_bridge_enable && $past(uart_bridge_enable)) |->
      dm_tx_oe && ulpi_d1_oe;
  endproperty

  a_style: assert property (p_style)
    else $error("reserved drive style on output");
  a_speed: assert property (p_speed)
    else $error("speed enables inconsistent");
  a_prot: assert property (p_prot)
    else $error("protect enable does not follow bit 7");
  a_lp: assert property (p_lp)
    else $error("low power without dir or with clock on");
  a_wake: assert property (p_wake)
    else $error("no report after low power exit");
  a_rst_hold: assert property (p_rst_hold)
    else $error("core reset too short or dir low");
  a_rst_end: assert property (p_rst_end)
    else $error("core reset hand-off order wrong");
  a_rd0: assert property (p_rd0)
    else $error("reserved or reset bit read as one");
  a_slverr: assert property (p_slverr)
    else $error("unmapped access not refused");
  a_uart: assert property (p_uart)
    else $error("uart lines not driven");
endmodule

bind ufic_top ufic_checker u_chk (.*);
`default_nettype wire

// >>> tb/ufic_link_model.sv
// Link controller model: free running link clock, stop and UART data.
`default_nettype none
module ufic_link_model (
  // Requests from the bench.
  input wire logic run,
  input wire logic stp_req,
  input wire logic d0_req,
  // Link pins.
  output var logic link_clk,
  output var logic link_stp,
  output var logic link_d0
);
  timeunit 1ns;
  timeprecision 1ps;
  initial link_clk = 1'b0;
  initial link_stp = 1'b0;
  initial link_d0 = 1'b1;

  // The link clock runs free, as a ULPI clock does, while enabled.
  always #80 link_clk = run ? ~link_clk : 1'b0;

  // UART transmit data
  // Stop and data change only after a link clock edge, as a link would.
  always @(posedge link_clk) begin
    link_stp <= stp_req;
    link_d0 <= d0_req;
  end
endmodule
`default_nettype wire

// >>> tb/test_ufic_top.sv
// Self-checking bench of the function and interface control block.
`default_nettype none
module test_ufic_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a, d, ra, rx; logic e;} ufic_row_t;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, r;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic link_clk, link_stp, link_d0, dir, ulpi_d1_out, ulpi_d1_oe;
  logic interface_protect_en, dp_rx, offchip_vbus_flag, vbus_valid_cmp;
  logic bus_resume_seen, dp_pulldown, dm_pulldown, dm_tx_out, dm_tx_oe;
  logic phy_low_power_n, core_reset, hs_xcvr_en, fs_xcvr_en, ls_xcvr_en;
  logic fs_preamble_en, hs_term_en, fs_pullup_en, serial_clock_on;
  logic resume_drive, uart_bridge_enable, three_wire_serial_enable;
  logic six_wire_serial_enable, rxcmd_send, rxcmd_vbus, e;
  logic run, stp_req, d0_req;
  logic [1:0] line_drive_style;
  logic [3:0] spx [4] = '{4'b1000, 4'b0100, 4'b0010, 4'b0101};
  int fail_count = 0;
  int checked = 0;
  int n;
  // Write, then read back; the last row is an unmapped write.
  ufic_row_t rows [10] = '{
    '{8'h10, 8'h4E, 8'h10, 8'h4E, 0}, '{8'h14, 8'h01, 8'h10, 8'h4F, 0},
    '{8'h18, 8'h0C, 8'h10, 8'h43, 0}, '{8'h18, 8'h20, 8'h10, 8'h43, 0},
    '{8'h10, 8'hC1, 8'h10, 8'h41, 0}, '{8'h1C, 8'h80, 8'h1C, 8'h80, 0},
    '{8'h20, 8'h28, 8'h1C, 8'hA8, 0}, '{8'h24, 8'h88, 8'h1C, 8'h20, 0},
    '{8'h24, 8'h20, 8'h1C, 8'h00, 0}, '{8'hFC, 8'hFF, 8'h10, 8'h41, 1}};

  ufic_top DUT (.*);
  ufic_link_model u_link (.*);

  // ========================================================================
  // Clock, watchdog and shared tasks.
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;
  initial begin
    #400000;
    fail_count++;
    print_verdict;
  end
  task print_verdict;
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] x);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, g, x);
    end
  endtask
  // APB register access
  // Setup, then access held until pready is seen high.
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x);
    apb(0, a, 8'h00);
    chk(r, x);
  endtask
  // Pins cross a two flop synchroniser; checks land at a falling edge.
  task settle;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task stp;
    @(posedge ref_clk) stp_req <= 1;
    repeat (48) @(posedge ref_clk);
    stp_req <= 0;
    repeat (48) @(posedge ref_clk);
    settle;
  endtask
  task vb(input logic [7:0] c, input logic f, input logic m, input logic x);
    wr(8'h1C, c);
    @(posedge ref_clk) offchip_vbus_flag <= f;
    vbus_valid_cmp <= m;
    settle;
    chk(rxcmd_vbus, x);
  endtask

  // ========================================================================
  // Main sequence.
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, stp_req} = '0;
    {offchip_vbus_flag, vbus_valid_cmp, bus_resume_seen} = '0;
    {dp_pulldown, dm_pulldown} = '0;
    {pstrb, run, d0_req, dp_rx} = 7'h7F;
    repeat (16) @(posedge ref_clk);
    rstn <= 1;
    rd(8'h10, 8'h41);
    rd(8'h1C, 8'h00);
    chk({interface_protect_en, fs_xcvr_en, dir}, 3'b110);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk(e, rows[i].e);
      rd(rows[i].ra, rows[i].rx);
    end
    @(posedge ref_clk) pstrb <= 4'h0;
    wr(8'h10, 8'h42);
    pstrb <= 4'hF;
    rd(8'h10, 8'h41);
    for (int s = 0; s < 4; s++) begin
      wr(8'h10, 8'h40 | s);
      settle;
      chk({hs_xcvr_en, fs_xcvr_en, ls_xcvr_en, fs_preamble_en}, spx[s]);
      wr(8'h10, 8'h40 | (s << 3));
      settle;
      chk(line_drive_style, s == 3 ? 0 : s);
    end
    wr(8'h10, 8'h44);
    settle;
    chk({hs_term_en, fs_pullup_en}, 2'b01);
    wr(8'h10, 8'h40);
    settle;
    chk({hs_term_en, fs_pullup_en}, 2'b10);
    @(posedge ref_clk) {dp_pulldown, dm_pulldown} <= 2'b11;
    wr(8'h10, 8'h45);
    settle;
    chk(fs_pullup_en, 0);
    // Twice, so a second request is shown to hold the core and report again.
    repeat (2) begin
      wr(8'h14, 8'h20);
      repeat (4) @(negedge ref_clk);
      chk({core_reset, dir}, 2'b11);
      rd(8'h10, 8'h45);
      for (n = 0; n < 600 && rxcmd_send !== 1'b1; n++) @(negedge ref_clk);
      chk({dir, core_reset, rxcmd_send}, 3'b101);
      rd(8'h10, 8'h45);
    end
    wr(8'h20, 8'h10);
    wr(8'h18, 8'h40);
    settle;
    chk({phy_low_power_n, dir, serial_clock_on}, 3'b010);
    rd(8'h40, 8'h05);
    chk(resume_drive, 0);
    @(posedge ref_clk) bus_resume_seen <= 1;
    settle;
    chk(resume_drive, 1);
    @(posedge ref_clk) bus_resume_seen <= 0;
    stp;
    chk({phy_low_power_n, resume_drive}, 2'b10);
    rd(8'h10, 8'h45);
    vb(8'h00, 1, 0, 0);
    vb(8'h00, 1, 1, 1);
    vb(8'h20, 0, 1, 1);
    vb(8'h60, 0, 0, 1);
    for (int b = 0; b < 3; b++) begin
      wr(8'h1C, 8'h01 << b);
      settle;
      chk({uart_bridge_enable, three_wire_serial_enable,
           six_wire_serial_enable}, 8'h01 << b);
      chk(serial_clock_on, 0);
      if (b == 2) begin
        @(posedge ref_clk) {d0_req, dp_rx} <= 2'b00;
        repeat (48) @(posedge ref_clk);
        settle;
        chk({dm_tx_out, ulpi_d1_out, dm_tx_oe, ulpi_d1_oe}, 4'b0011);
        @(posedge ref_clk) {d0_req, dp_rx} <= 2'b11;
      end
      wr(8'h20, 8'h08);
      settle;
      chk(serial_clock_on, 1);
      stp;
      rd(8'h1C, 8'h08);
    end
    print_verdict;
  end
endmodule
`default_nettype wire
